/* File: shared/ccdrs_pkg.sv */
package ccdrs_pkg;
    // array geometry, rows in readout order
    localparam int SHIELD_ROWS  = 10;
    localparam int PHOTO_ROWS   = 2062;
    localparam int TOTAL_ROWS   = SHIELD_ROWS + PHOTO_ROWS;
    localparam int TOP_BUF_ROWS = 6;
    localparam int BOT_BUF_ROWS = 8;
    localparam int VALID_ROWS   = 2048;
    // horizontal register layout
    localparam int EMPTY_PIX    = 12;
    localparam int DARK_COLS    = 28;
    localparam int PHOTO_PIX    = 2056;
    localparam int LINE_PIX     = 2124;
    localparam int HALF_PIX     = 1068;
    localparam int HALF_PHOTO   = 1028;
    localparam int ARRAY_COLS   = 2112;
    localparam int BUF_PIX      = 4;
    localparam int VALID_PIX    = 2048;
    localparam int HALF_VALID   = VALID_PIX / 2;
    localparam int DARK_USED    = 26;
    localparam int FIRST_VALID  = EMPTY_PIX + DARK_COLS + BUF_PIX;
    localparam int FIRST_DARK   = EMPTY_PIX + 1;
    // widths
    localparam int PIX_W        = 12;
    localparam int ROW_W        = 12;
    localparam int COL_W        = 12;
    localparam int HBUF_AW      = 10;
    localparam int DARK_W       = PIX_W + 5;
    // timing at a 50 ns clock, least times rounded up
    localparam int CLK_NS                = 50;
    localparam int RESTART_DELAY_NS      = 1000;
    localparam int RESTART_CYC           =
        (RESTART_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int VPULSE_NS             = 1000;
    localparam int VPULSE_CYC            = (VPULSE_NS + CLK_NS - 1) / CLK_NS;

    typedef logic [PIX_W-1:0] ccdrs_pix_t;
endpackage

/* File: shared/ccdrs_link_if.sv */
`timescale 1ns/1ns
// pins between the sensor and its timing generator
interface ccdrs_link_if;
    logic                   vertical_phase_one;
    logic                   vertical_phase_two;
    logic                   fast_line_dump;
    logic                   shutter_pulse;
    logic                   phase_a_storage_left;
    logic                   phase_a_barrier_left;
    logic                   phase_a_storage_right;
    logic                   phase_a_barrier_right;
    logic                   phase_b_storage_left;
    logic                   phase_b_barrier_left;
    logic                   phase_b_storage_right;
    logic                   phase_b_barrier_right;
    ccdrs_pkg::ccdrs_pix_t  video_left;
    ccdrs_pkg::ccdrs_pix_t  video_right;

    modport sensor (
        input  vertical_phase_one, vertical_phase_two, fast_line_dump,
        input  shutter_pulse,
        input  phase_a_storage_left, phase_a_barrier_left,
        input  phase_a_storage_right, phase_a_barrier_right,
        input  phase_b_storage_left, phase_b_barrier_left,
        input  phase_b_storage_right, phase_b_barrier_right,
        output video_left, video_right
    );
    modport timing (
        output vertical_phase_one, vertical_phase_two, fast_line_dump,
        output shutter_pulse,
        output phase_a_storage_left, phase_a_barrier_left,
        output phase_a_storage_right, phase_a_barrier_right,
        output phase_b_storage_left, phase_b_barrier_left,
        output phase_b_storage_right, phase_b_barrier_right,
        input  video_left, video_right
    );
endinterface

/* File: core/ccdrs_edge.sv */
`timescale 1ns/1ns
// one-cycle rise and fall strobes of a synchronous level
module ccdrs_edge
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic level,
    output logic      rise,
    output logic      fall
);
    logic prev_q;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            prev_q <= level; // idle level, so no false edge after reset
        else
            prev_q <= level;
    end

    assign rise = level & ~prev_q;
    assign fall = ~level & prev_q;
endmodule

/* File: core/ccdrs_sensor.sv */
`timescale 1ns/1ns
// behavioural sensor end: row transfer, line dump, horizontal shift
module ccdrs_sensor
    import ccdrs_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    ccdrs_link_if.sensor                 link,
    output logic [ccdrs_pkg::ROW_W-1:0]  scene_row,
    output logic [ccdrs_pkg::COL_W-1:0]  scene_col_left,
    output logic [ccdrs_pkg::COL_W-1:0]  scene_col_right,
    input  wire ccdrs_pkg::ccdrs_pix_t   scene_charge_left,
    input  wire ccdrs_pkg::ccdrs_pix_t   scene_charge_right,
    output logic                         line_dumped
);
    import ccdrs_pkg::*;

    localparam logic [COL_W-1:0] EMPTY = COL_W'(EMPTY_PIX);
    localparam logic [COL_W-1:0] HALF  = COL_W'(HALF_PIX);
    localparam logic [COL_W-1:0] LEFT_END = COL_W'(EMPTY_PIX + ARRAY_COLS);
    localparam logic [COL_W-1:0] LAST_COL = COL_W'(ARRAY_COLS - 1);
    localparam logic [COL_W-1:0] LINE  = COL_W'(LINE_PIX);
    localparam logic [ROW_W-1:0] ROWS  = ROW_W'(TOTAL_ROWS);

    logic             xfer;
    logic             hshift;
    logic             vpulse;
    logic             dual;
    logic             dump_seen_q;
    logic             dumped_q;
    logic [ROW_W-1:0] row_q;
    logic [ROW_W-1:0] line_row_q;
    logic [COL_W-1:0] pos_q;
    ccdrs_pix_t       vid_l_q;
    ccdrs_pix_t       vid_r_q;

    // transfer ends when either vertical phase falls
    assign vpulse = link.vertical_phase_one & link.vertical_phase_two;

    ccdrs_edge u_vedge
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .level   (vpulse),
        .rise    (),
        .fall    (xfer)
    );

    ccdrs_edge u_hedge
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .level   (link.phase_a_storage_left),
        .rise    (hshift),
        .fall    ()
    );

    // right barrier following phase a reverses the right half
    assign dual = link.phase_a_barrier_right == link.phase_a_storage_left;

    // column under each output for the pixel the next shift puts out
    wire in_left  = pos_q >= EMPTY && pos_q < (dual ? HALF : LEFT_END);
    wire in_right = dual && pos_q >= EMPTY && pos_q < HALF;
    wire [COL_W-1:0] col_l = pos_q - EMPTY;
    wire [COL_W-1:0] col_r = LAST_COL - col_l;

    assign scene_row       = line_row_q;
    assign scene_col_left  = col_l;
    assign scene_col_right = col_r;
    assign line_dumped     = dumped_q;
    assign link.video_left  = vid_l_q;
    assign link.video_right = vid_r_q;

    // vertical side: dump held anywhere in the pulse discards the row
    always_ff @(posedge sys_clk)
    begin
        if (rst || link.shutter_pulse)
        begin
            row_q       <= '0;
            line_row_q  <= '0;
            dump_seen_q <= 1'b0;
            dumped_q    <= 1'b1;
        end
        else if (xfer)
        begin
            row_q       <= (row_q == ROWS - 1'b1) ? '0 : row_q + 1'b1;
            line_row_q  <= row_q;
            dumped_q    <= dump_seen_q;
            dump_seen_q <= 1'b0;
        end
        else if (vpulse && link.fast_line_dump)
            dump_seen_q <= 1'b1;
    end

    // horizontal side: one pixel per rising phase a, empty ends read 0
    always_ff @(posedge sys_clk)
    begin
        if (rst || xfer)
        begin
            pos_q   <= '0;
            vid_l_q <= '0;
            vid_r_q <= '0;
        end
        else if (hshift)
        begin
            pos_q   <= (pos_q == LINE) ? pos_q : pos_q + 1'b1;
            vid_l_q <= (in_left && !dumped_q) ? scene_charge_left : '0;
            vid_r_q <= (in_right && !dumped_q) ? scene_charge_right : '0;
        end
    end
endmodule

/* File: core/ccdrs_timing.sv */
`timescale 1ns/1ns
// Behaviour
// - frame is 10 shielded plus 2062 photoactive rows
// - only 2048 rows past the buffer rows are valid
// - single output clocks 2124 pixels per line
// - four buffer pixels each side are discarded
// - dual output: right half reversed, 1068 each
// - right line stored, reversed, appended after left
// - bottom dark rows never used as black
// - dark level sums central 26 of 28 columns
// - each vertical pulse moves rows one step
// - vertical shift: phase a high, b low
// - horizontal restart waits the restart delay
// - dump high during transfer discards the line
// - horizontal register: 2112 columns, empty ends
// - no vertical, dump or shutter during shifting
// - halves same direction single, opposite dual
// - single mode barrier wiring per phase
module ccdrs_timing
    import ccdrs_pkg::*;
(
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    ccdrs_link_if.timing                  link,
    input  wire logic                     start,
    input  wire logic                     dual_mode,
    output logic                          busy,
    output logic                          pix_valid,
    output ccdrs_pkg::ccdrs_pix_t         pix_data,
    output logic [ccdrs_pkg::DARK_W-1:0]  dark_sum,
    output logic                          dark_valid,
    output logic                          frame_done
);
    import ccdrs_pkg::*;

    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b000,
        ST_SHUT   = 3'b001,
        ST_VXFER  = 3'b010,
        ST_HOLD   = 3'b011,
        ST_HSHIFT = 3'b100,
        ST_EMIT   = 3'b101
    } ccdrs_state_t;

    localparam logic [ROW_W-1:0] R_LAST   = ROW_W'(TOTAL_ROWS - 1);
    localparam logic [ROW_W-1:0] R_SHIELD = ROW_W'(SHIELD_ROWS);
    localparam logic [ROW_W-1:0] R_VAL0   = ROW_W'(SHIELD_ROWS + TOP_BUF_ROWS);
    localparam logic [ROW_W-1:0] R_VALEND =
        ROW_W'(SHIELD_ROWS + TOP_BUF_ROWS + VALID_ROWS);
    localparam logic [COL_W-1:0] P_LINE   = COL_W'(LINE_PIX);
    localparam logic [COL_W-1:0] P_HALF   = COL_W'(HALF_PIX);
    localparam logic [COL_W-1:0] P_VAL0   = COL_W'(FIRST_VALID);
    localparam logic [COL_W-1:0] P_VALS   = COL_W'(FIRST_VALID + VALID_PIX);
    localparam logic [COL_W-1:0] P_VALD   = COL_W'(FIRST_VALID + HALF_VALID);
    localparam logic [COL_W-1:0] P_DARK0  = COL_W'(FIRST_DARK);
    localparam logic [COL_W-1:0] P_DARKE  = COL_W'(FIRST_DARK + DARK_USED);
    localparam logic [HBUF_AW-1:0] B_LAST = HBUF_AW'(HALF_VALID - 1);
    localparam logic [7:0] V_LAST = 8'(VPULSE_CYC - 1);
    localparam logic [7:0] H_LAST = 8'(RESTART_CYC - 1);

    ccdrs_state_t       state_q;
    ccdrs_state_t       state_d;
    logic               dual_q;
    logic               dual_d;
    logic [ROW_W-1:0]   row_q;
    logic [ROW_W-1:0]   row_d;
    logic [COL_W-1:0]   pix_q;
    logic [COL_W-1:0]   pix_d;
    logic [7:0]         cnt_q;
    logic [7:0]         cnt_d;
    logic [HBUF_AW-1:0] rd_q;
    logic [HBUF_AW-1:0] rd_d;
    logic               ha_q;
    logic               ha_d;
    logic               next_row;
    logic               pix_valid_q;
    ccdrs_pix_t         pix_data_q;
    logic [DARK_W-1:0]  dark_acc_q;
    logic [DARK_W-1:0]  dark_sum_q;
    logic               dark_valid_q;
    logic               frame_done_q;
    ccdrs_pix_t         rbuf [0:HALF_VALID-1];

    // line geometry and capture decode
    wire [COL_W-1:0] line_len = dual_q ? P_HALF : P_LINE;
    wire [COL_W-1:0] ci       = pix_q - 1'b1;
    wire capture   = state_q == ST_HSHIFT && !ha_q && pix_q != '0;
    wire line_end  = state_q == ST_HSHIFT && !ha_q && pix_q == line_len;
    wire dump_row  = row_q < R_SHIELD;
    wire valid_row = row_q >= R_VAL0 && row_q < R_VALEND;
    wire left_ok   = ci >= P_VAL0 && ci < (dual_q ? P_VALD : P_VALS);
    wire right_ok  = dual_q && ci >= P_VAL0 && ci < P_VALD;
    wire dark_ok   = ci >= P_DARK0 && ci < P_DARKE;
    wire emit      = state_q == ST_EMIT;
    wire [HBUF_AW-1:0] wr_addr = HBUF_AW'(ci - P_VAL0);
    wire [HBUF_AW-1:0] rd_addr = B_LAST - rd_q;

    // pins: vertical, dump and shutter only outside shifting
    assign link.vertical_phase_one = state_q == ST_VXFER;
    assign link.vertical_phase_two = state_q == ST_VXFER;
    assign link.fast_line_dump = state_q == ST_VXFER && dump_row;
    assign link.shutter_pulse  = state_q == ST_SHUT;
    // phase b is always the complement of phase a
    assign link.phase_a_storage_left  = ha_q;
    assign link.phase_a_barrier_left  = ha_q;
    assign link.phase_a_storage_right = ha_q;
    assign link.phase_b_storage_left  = ~ha_q;
    assign link.phase_b_barrier_left  = ~ha_q;
    assign link.phase_b_storage_right = ~ha_q;
    // right barriers follow phase a only in dual mode, reversing the right half
    assign link.phase_a_barrier_right = dual_q ? ha_q : ~ha_q;
    assign link.phase_b_barrier_right = dual_q ? ~ha_q : ha_q;

    assign busy       = state_q != ST_IDLE;
    assign pix_valid  = pix_valid_q;
    assign pix_data   = pix_data_q;
    assign dark_sum   = dark_sum_q;
    assign dark_valid = dark_valid_q;
    assign frame_done = frame_done_q;

    // sequencer: shutter, then per row transfer, hold, and shift for rows not dumped
    always_comb
    begin
        state_d  = state_q;
        dual_d   = dual_q;
        row_d    = row_q;
        pix_d    = pix_q;
        cnt_d    = cnt_q;
        rd_d     = rd_q;
        ha_d     = ha_q;
        next_row = 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                if (start)
                begin
                    dual_d  = dual_mode;
                    row_d   = '0;
                    state_d = ST_SHUT;
                end
            end
            ST_SHUT:
            begin
                cnt_d   = '0;
                state_d = ST_VXFER;
            end
            ST_VXFER:
            begin
                // phase a held high, b low through the pulse
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == V_LAST)
                begin
                    cnt_d   = '0;
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == H_LAST)
                begin
                    cnt_d = '0;
                    pix_d = '0;
                    if (dump_row)
                        next_row = 1'b1;
                    else
                        state_d = ST_HSHIFT;
                end
            end
            ST_HSHIFT:
            begin
                // two cycles a pixel; sample while phase a is low
                if (ha_q)
                    ha_d = 1'b0;
                else if (pix_q == line_len)
                begin
                    ha_d = 1'b1;
                    rd_d = '0;
                    if (dual_q && valid_row)
                        state_d = ST_EMIT;
                    else
                        next_row = 1'b1;
                end
                else
                begin
                    ha_d  = 1'b1;
                    pix_d = pix_q + 1'b1;
                end
            end
            ST_EMIT:
            begin
                rd_d = rd_q + 1'b1;
                if (rd_q == B_LAST)
                    next_row = 1'b1;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
        // all 2072 rows go through the transfer before the frame ends
        if (next_row)
        begin
            row_d   = row_q + 1'b1;
            state_d = (row_q == R_LAST) ? ST_IDLE : ST_VXFER;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            dual_q  <= 1'b0;
            row_q   <= '0;
            pix_q   <= '0;
            cnt_q   <= '0;
            rd_q    <= '0;
            ha_q    <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            dual_q  <= dual_d;
            row_q   <= row_d;
            pix_q   <= pix_d;
            cnt_q   <= cnt_d;
            rd_q    <= rd_d;
            ha_q    <= ha_d;
        end
    end

    // right line buffer, no reset needed on the storage itself
    always_ff @(posedge sys_clk)
    begin
        if (capture && right_ok && valid_row)
            rbuf[wr_addr] <= link.video_right;
    end

    // pixel stream: left valid pixels, then in dual mode the reversed right line
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pix_valid_q <= 1'b0;
            pix_data_q  <= '0;
        end
        else
        begin
            pix_valid_q <= (capture && valid_row && left_ok) || emit;
            pix_data_q  <= emit ? rbuf[rd_addr] : link.video_left;
        end
    end

    // black level from dark columns only, published at each line end
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            dark_acc_q   <= '0;
            dark_sum_q   <= '0;
            dark_valid_q <= 1'b0;
            frame_done_q <= 1'b0;
        end
        else
        begin
            dark_valid_q <= line_end;
            frame_done_q <= next_row && row_q == R_LAST;
            if (line_end)
            begin
                dark_sum_q <= dark_acc_q;
                dark_acc_q <= '0;
            end
            else if (capture && dark_ok)
                dark_acc_q <= dark_acc_q + DARK_W'(link.video_left);
        end
    end
endmodule

/* File: tb/ccdrs_link_sva.sv */
`timescale 1ns/1ns
// protocol watcher on the link between generator and sensor
module ccdrs_link_sva
    import ccdrs_pkg::*;
(
    input wire logic                  sys_clk,
    input wire logic                  rst,
    input wire logic                  vertical_phase_one,
    input wire logic                  vertical_phase_two,
    input wire logic                  fast_line_dump,
    input wire logic                  shutter_pulse,
    input wire logic                  phase_a_storage_left,
    input wire logic                  phase_a_barrier_left,
    input wire logic                  phase_a_storage_right,
    input wire logic                  phase_a_barrier_right,
    input wire logic                  phase_b_storage_left,
    input wire logic                  phase_b_barrier_left,
    input wire logic                  phase_b_storage_right,
    input wire logic                  phase_b_barrier_right,
    input wire ccdrs_pkg::ccdrs_pix_t video_left,
    input wire ccdrs_pkg::ccdrs_pix_t video_right
);
    import ccdrs_pkg::*;

    logic [15:0] hold_q;
    logic [7:0]  vcnt_q;
    logic [11:0] shift_q;
    logic        pa_q;
    logic        rise;
    logic        single_mode;

    // single mode runs the right barrier against phase a
    assign rise        = phase_a_storage_left & ~pa_q;
    assign single_mode = phase_a_barrier_right != phase_a_storage_left;

    // counters: idle time since transfer, pulse width, shifts per line
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            hold_q  <= 16'h0000;
            vcnt_q  <= 8'h00;
            shift_q <= 12'h000;
            pa_q    <= 1'b1;
        end
        else
        begin
            hold_q  <= vertical_phase_one ? 16'h0000 :
                       hold_q + 16'(hold_q != 16'hffff); // saturate
            vcnt_q  <= vertical_phase_one ? vcnt_q + 8'h01 : 8'h00;
            shift_q <= (vertical_phase_one || shutter_pulse) ? 12'h000 :
                       shift_q + 12'(rise);
            pa_q    <= phase_a_storage_left;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_vert_hold;
        vertical_phase_one |-> phase_a_storage_left && !phase_b_storage_left;
    endproperty
    a_vert_hold: assert property (p_vert_hold)
        else $error("horizontal phases not parked during row shift");

    property p_phase_pair;
        phase_b_storage_left == !phase_a_storage_left &&
        phase_b_storage_right == !phase_a_storage_right &&
        phase_b_barrier_left == !phase_a_barrier_left;
    endproperty
    a_phase_pair: assert property (p_phase_pair)
        else $error("horizontal phases not complementary");

    property p_left_group;
        phase_a_barrier_left == phase_a_storage_left &&
        phase_a_storage_right == phase_a_storage_left;
    endproperty
    a_left_group: assert property (p_left_group)
        else $error("phase a pins out of step");

    property p_barrier_pair;
        phase_b_barrier_right == !phase_a_barrier_right;
    endproperty
    a_barrier_pair: assert property (p_barrier_pair)
        else $error("right barrier pins not complementary");

    property p_restart;
        $fell(phase_a_storage_left) |-> hold_q >= 16'(RESTART_CYC);
    endproperty
    a_restart: assert property (p_restart)
        else $error("horizontal clocking restarted too early");

    property p_vpulse;
        $fell(vertical_phase_one) |-> vcnt_q == 8'(VPULSE_CYC);
    endproperty
    a_vpulse: assert property (p_vpulse)
        else $error("vertical pulse width wrong");

    property p_v_pair;
        vertical_phase_one == vertical_phase_two;
    endproperty
    a_v_pair: assert property (p_v_pair)
        else $error("vertical phases not pulsed together");

    property p_quiet;
        !phase_a_storage_left |->
            !vertical_phase_one && !fast_line_dump && !shutter_pulse;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("pulse on a quiet input while shifting");

    property p_dump_in_pulse;
        fast_line_dump |-> vertical_phase_one;
    endproperty
    a_dump_in_pulse: assert property (p_dump_in_pulse)
        else $error("line dump outside a row transfer");

    property p_line_len;
        $rose(vertical_phase_one) |-> shift_q == 12'h000 ||
            shift_q == (single_mode ? 12'(LINE_PIX) : 12'(HALF_PIX));
    endproperty
    a_line_len: assert property (p_line_len)
        else $error("wrong number of horizontal clocks in a line");

    property p_empty_start;
        $fell(vertical_phase_one) |->
            ##[1:3] video_left == '0 && video_right == '0;
    endproperty
    a_empty_start: assert property (p_empty_start)
        else $error("video not empty after row transfer");

    c_shutter: cover property (shutter_pulse);
    c_dump: cover property (fast_line_dump && vertical_phase_one);
    c_dual_line: cover property ($rose(vertical_phase_one) &&
        shift_q == 12'(HALF_PIX));
endmodule

/* File: tb/tb_ccd_readout_sequencing.sv */
`timescale 1ns/1ns
// generator and sensor face to face; one frame start in each mode
module tb_ccd_readout_sequencing
    import ccdrs_pkg::*;
;
    import ccdrs_pkg::*;

    logic              sys_clk = 1'b0;
    logic              rst = 1'b1;
    logic              start = 1'b0;
    logic              dual_mode = 1'b0;
    logic              busy;
    logic              pix_valid;
    logic              dark_valid;
    logic              frame_done;
    logic              line_dumped;
    ccdrs_pix_t        pix_data;
    ccdrs_pix_t        charge_l;
    ccdrs_pix_t        charge_r;
    logic [DARK_W-1:0] dark_sum;
    logic [ROW_W-1:0]  scene_row;
    logic [COL_W-1:0]  col_l;
    logic [COL_W-1:0]  col_r;
    int                bad_count = 0;
    int                total_checks = 0;

    ccdrs_link_if link();

    always #25 sys_clk = ~sys_clk;

    // scene charge: column with row folded into the top bits
    function automatic ccdrs_pix_t scene_val(input logic [ROW_W-1:0] row,
                                             input logic [COL_W-1:0] col);
        return col ^ {row[5:0], 6'h00};
    endfunction

    assign charge_l = scene_val(scene_row, col_l);
    assign charge_r = scene_val(scene_row, col_r);

    ccdrs_sensor ccdrs_sensor_i (
        .sys_clk            (sys_clk),
        .rst                (rst),
        .link               (link.sensor),
        .scene_row          (scene_row),
        .scene_col_left     (col_l),
        .scene_col_right    (col_r),
        .scene_charge_left  (charge_l),
        .scene_charge_right (charge_r),
        .line_dumped        (line_dumped)
    );

    ccdrs_timing ccdrs_timing_i (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .link       (link.timing),
        .start      (start),
        .dual_mode  (dual_mode),
        .busy       (busy),
        .pix_valid  (pix_valid),
        .pix_data   (pix_data),
        .dark_sum   (dark_sum),
        .dark_valid (dark_valid),
        .frame_done (frame_done)
    );

    ccdrs_link_sva ccdrs_link_sva_i (
        .sys_clk               (sys_clk),
        .rst                   (rst),
        .vertical_phase_one    (link.vertical_phase_one),
        .vertical_phase_two    (link.vertical_phase_two),
        .fast_line_dump        (link.fast_line_dump),
        .shutter_pulse         (link.shutter_pulse),
        .phase_a_storage_left  (link.phase_a_storage_left),
        .phase_a_barrier_left  (link.phase_a_barrier_left),
        .phase_a_storage_right (link.phase_a_storage_right),
        .phase_a_barrier_right (link.phase_a_barrier_right),
        .phase_b_storage_left  (link.phase_b_storage_left),
        .phase_b_barrier_left  (link.phase_b_barrier_left),
        .phase_b_storage_right (link.phase_b_storage_right),
        .phase_b_barrier_right (link.phase_b_barrier_right),
        .video_left            (link.video_left),
        .video_right           (link.video_right)
    );

    task automatic check(input logic [DARK_W-1:0] got,
                         input logic [DARK_W-1:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        if (bad_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one frame start, a refused start, then the first valid row
    task automatic run_frame(input logic dual);
        int                k;
        int                n;
        logic              dark_seen;
        logic [DARK_W-1:0] exp_dark;
        logic [DARK_W-1:0] exp_d;
        logic              dump_exp;
        exp_dark = '0;
        for (n = 1; n <= DARK_USED; n++)
            exp_dark += DARK_W'(scene_val(ROW_W'(SHIELD_ROWS), COL_W'(n)));
        @(posedge sys_clk);
        start     <= 1'b1;
        dual_mode <= dual;
        @(posedge sys_clk);
        start <= 1'b0;
        #1;
        check(DARK_W'(busy), 17'h0_0001);
        check(DARK_W'(link.shutter_pulse), 17'h0_0001);
        // a start while busy, other mode, must change nothing
        @(posedge sys_clk);
        start     <= 1'b1;
        dual_mode <= ~dual;
        @(posedge sys_clk);
        start <= 1'b0;
        k = 0;
        n = 0;
        dark_seen = 1'b0;
        while (k < VALID_PIX && n < 60000)
        begin
            @(posedge sys_clk);
            #1;
            n++;
            // shielded rows only are dumped; no frame end this early
            dump_exp = scene_row < ROW_W'(SHIELD_ROWS);
            check(DARK_W'(line_dumped), DARK_W'(dump_exp));
            check(DARK_W'(frame_done), 17'h0_0000);
            if (dark_valid === 1'b1 && !dark_seen)
            begin
                check(dark_sum, exp_dark);
                dark_seen = 1'b1;
            end
            if (pix_valid === 1'b1)
            begin
                exp_d = DARK_W'(scene_val(ROW_W'(SHIELD_ROWS + TOP_BUF_ROWS),
                    COL_W'(FIRST_VALID - EMPTY_PIX + k)));
                check(DARK_W'(pix_data), exp_d);
                k++;
            end
        end
        check(DARK_W'(k), DARK_W'(VALID_PIX));
        check(DARK_W'(dark_seen), 17'h0_0001);
    endtask

    // mid-frame reset; a full frame would far outrun the cycle budget
    task automatic do_reset;
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
    endtask

    initial
    begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        run_frame(1'b0);
        do_reset();
        run_frame(1'b1);
        end_of_test();
    end

    // watchdog well past two partial frames, under the cycle budget
    initial
    begin
        #(50 * 90000);
        bad_count++;
        end_of_test();
    end
endmodule
